// ===== verilog/quad_dac_double_buffer_ctrl.sv
`timescale 1ns/10ps
// Contract
// - Four channels, each code 8, 10 or 12 bits wide.
// - Command word routes data to config, one channel or several.
// - Pending register per channel, written by code and code-load.
// - Code-load command writes the active register directly.
// - Load command or hardware strobe copies pending into active.
// - Power-down leaves pending and active registers untouched.
// - Writes and loads still work during power-down.
// - Soft wipe and soft restart zero every pending and active code.
// - Power-on reset sets every active register to zero.
// - Reset and soft restart select the external reference.
// - Software picks internal reference 2.048, 2.500 or 4.096 volts.
// - Low hardware strobe updates all enabled channels together.
// - Held low strobe makes active registers transparent.
// - A config command enables the strobe per channel.
// - Clear input acts asynchronously, independent of commands.
// - Clear zeroes all codes and aborts any command in progress.
// - Commands are ignored during the 200 us power-up calibration.
module quad_dac_double_buffer_ctrl #(
  parameter int CODE_W = quad_dac_pkg::CODE_W_DEF,
  parameter int CAL_CYCLES = quad_dac_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [quad_dac_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [quad_dac_pkg::APB_DW-1:0] pwdata,
  output logic [quad_dac_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hwUpdateN,
  input wire logic asyncWipeN,
  output logic [quad_dac_pkg::NUM_CH*CODE_W-1:0] activeCode,
  output logic [quad_dac_pkg::NUM_CH-1:0] powerDown,
  output quad_dac_pkg::ref_sel_e refSel,
  output logic calibrating
);
  import quad_dac_pkg::*;

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef logic [CODE_W-1:0] code_t;

  typedef enum logic [2:0] {
    ST_CAL = 3'b001,
    ST_RUN = 3'b010,
    ST_WIPE = 3'b100
  } state_e;

  function automatic logic [APB_DW-1:0] widen(input code_t c);
    widen = {{(APB_DW-CODE_W){1'b0}}, c};
  endfunction

  // ****************************************************************
  // Clear and strobe synchronisation
  // ****************************************************************
  logic wipeAsync;
  logic wipeHold;
  logic hwSyncN;
  logic calBusy;

  // The clear pin resets the code registers at once; the synchronised
  // copy keeps commands locked out until its release is clean.
  assign wipeAsync = rst | ~asyncWipeN;

  sync_two_ff #(.RST_VAL(1'b1)) uWipeSync (
    .clk(clk),
    .arst(wipeAsync),
    .d(1'b0),
    .q(wipeHold)
  );

  sync_two_ff #(.RST_VAL(1'b1)) uStrobeSync (
    .clk(clk),
    .arst(rst),
    .d(hwUpdateN),
    .q(hwSyncN)
  );

  calib_timer #(.CYCLES(CAL_CYCLES)) uCal (
    .clk(clk),
    .rst(rst),
    .busy(calBusy)
  );

  // ****************************************************************
  // Control state
  // ****************************************************************
  state_e state_q;
  state_e state_d;

  always_comb begin
    case (state_q)
      ST_CAL: state_d = calBusy ? ST_CAL : ST_RUN;
      ST_RUN: state_d = wipeHold ? ST_WIPE : ST_RUN;
      ST_WIPE: state_d = wipeHold ? ST_WIPE : ST_RUN;
      default: state_d = ST_CAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_CAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  cmd_s cmd;
  logic apbAccess;
  logic apbWr;
  logic cmdHit;
  logic statusHit;
  logic actHit;
  logic pendHit;
  logic mapped;
  logic cmdOpen;
  logic cmdFire;
  logic [1:0] rdIdx;

  assign cmd = cmd_s'(pwdata);
  assign apbAccess = psel & penable;
  assign apbWr = apbAccess & pwrite;
  assign cmdHit = paddr == OFF_CMD;
  assign statusHit = paddr == OFF_STATUS;
  assign actHit = paddr[7:4] == OFF_ACT0[7:4] && paddr[1:0] == 2'h0;
  assign pendHit = paddr[7:4] == OFF_PEND0[7:4] && paddr[1:0] == 2'h0;
  assign rdIdx = paddr[3:2];
  assign mapped = pwrite ? cmdHit : (statusHit | actHit | pendHit);
  // Commands are taken only when calibration is over and clear is off.
  assign cmdOpen = state_q == ST_RUN && !wipeHold;
  assign cmdFire = apbWr & cmdHit & cmdOpen;
  assign pready = 1'b1;
  assign pslverr = apbAccess & (~mapped | (pwrite & cmdHit & ~cmdOpen));

  logic opCode;
  logic opLoad;
  logic opCodeLoad;
  logic softZero;
  assign opCode = cmdFire && cmd.op == OP_CODE;
  assign opLoad = cmdFire && cmd.op == OP_LOAD;
  assign opCodeLoad = cmdFire && cmd.op == OP_CODE_LOAD;
  assign softZero = cmdFire &&
    (cmd.op == OP_SOFT_WIPE || cmd.op == OP_SOFT_RESTART);

  // ****************************************************************
  // Configuration
  // ****************************************************************
  logic [NUM_CH-1:0] hwEn_q;
  logic [NUM_CH-1:0] pwdn_q;
  ref_sel_e ref_q;
  logic restart;
  assign restart = cmdFire && cmd.op == OP_SOFT_RESTART;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hwEn_q <= RST_HW_EN;
      pwdn_q <= RST_PWDN;
      ref_q <= RST_REF;
    end else if (restart) begin
      hwEn_q <= RST_HW_EN;
      pwdn_q <= RST_PWDN;
      ref_q <= RST_REF;
    end else if (cmdFire && cmd.op == OP_HW_CFG) begin
      hwEn_q <= cmd.mask;
    end else if (cmdFire && cmd.op == OP_POWER) begin
      pwdn_q <= cmd.mask;
    end else if (cmdFire && cmd.op == OP_REF) begin
      ref_q <= ref_sel_e'(cmd.data[1:0]);
    end
  end

  // ****************************************************************
  // Channel code registers
  // ****************************************************************
  code_t pend_q [NUM_CH];
  code_t act_q [NUM_CH];
  code_t pend_d [NUM_CH];
  code_t act_d [NUM_CH];
  logic [NUM_CH-1:0] hwLoad;
  code_t newCode;
  assign newCode = cmd.data[CODE_W-1:0];

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic sel;
    assign sel = cmd.mask[ch];
    // Strobe level, not edge: while low the copy repeats every cycle.
    assign hwLoad[ch] = ~hwSyncN & hwEn_q[ch];
    // Power-down state is not consulted, so writes go on during it.
    assign pend_d[ch] = softZero ? '0 :
      (sel & (opCode | opCodeLoad)) ? newCode : pend_q[ch];
    assign act_d[ch] = softZero ? '0 :
      (sel & opCodeLoad) ? newCode :
      ((sel & opLoad) | hwLoad[ch]) ? pend_d[ch] : act_q[ch];

    always_ff @(posedge clk or posedge wipeAsync) begin
      if (wipeAsync) begin
        pend_q[ch] <= '0;
        act_q[ch] <= '0;
      end else begin
        pend_q[ch] <= pend_d[ch];
        act_q[ch] <= act_d[ch];
      end
    end

    assign activeCode[ch*CODE_W +: CODE_W] = act_q[ch];
  end

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************
  status_s status;
  logic [APB_DW-1:0] rdMux;
  always_comb begin
    status = '0;
    status.hwEn = hwEn_q;
    status.pwdn = pwdn_q;
    status.refSel = ref_q;
    status.cal = calBusy;
    status.wipe = wipeHold;
  end

  assign rdMux = statusHit ? APB_DW'(status) :
    actHit ? widen(act_q[rdIdx]) :
    pendHit ? widen(pend_q[rdIdx]) : '0;

  // Captured in the setup phase so prdata is a flop and pready stays 1.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdMux;
    end
  end

  assign powerDown = pwdn_q;
  assign refSel = ref_q;
  assign calibrating = calBusy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Checks are off while reset or the clear pin is active, because the
  // codes are then forced to zero whatever the bus is doing.
  default clocking cb @(posedge clk); endclocking
  default disable iff (wipeAsync);

  AST_SOFT_ZERO: assert property (softZero |=> activeCode == '0
    && pend_q[0] == '0 && pend_q[3] == '0)
    else $error("soft zero left a code set");
  AST_CODE_ONLY: assert property (
    opCode && cmd.mask[0] && !hwLoad[0] |=>
    pend_q[0] == $past(newCode) && $stable(act_q[0]))
    else $error("code write wrong");
  AST_CODE_LOAD: assert property (
    opCodeLoad && cmd.mask[1] |=> act_q[1] == $past(newCode))
    else $error("code load did not reach active");
  AST_LOAD: assert property (opLoad && cmd.mask[2] |=>
    act_q[2] == $past(pend_q[2]))
    else $error("load did not copy pending");
  AST_TRANSPARENT: assert property (
    hwLoad[0] [*2] |-> act_q[0] == $past(pend_d[0]))
    else $error("strobe not transparent");
  AST_HW_MASKED: assert property (
    !hwEn_q[1] && !cmdFire |=> $stable(act_q[1]))
    else $error("masked channel changed");
  AST_CAL_IGNORE: assert property (
    calBusy && apbWr && cmdHit |-> pslverr ##1 $stable(pend_q[0]))
    else $error("command taken during calibration");
  AST_WIPE_HOLD: assert property (wipeHold |->
    activeCode == '0 && !cmdFire)
    else $error("codes not held clear");
  AST_RESTART_REF: assert property (restart |=>
    refSel == REF_EXT && hwEn_q == RST_HW_EN)
    else $error("restart kept reference");
  AST_PWDN_KEEP: assert property (
    cmdFire && cmd.op == OP_POWER && hwSyncN |=> $stable(activeCode))
    else $error("power command changed codes");
  AST_CAL_LEN: assert property (
    $fell(calBusy) |-> state_q == ST_CAL ##1 state_q == ST_RUN)
    else $error("calibration end not seen");

  COV_CODE_THEN_LOAD: cover property (opCode ##[1:20] opLoad);
  COV_STROBE_HELD: cover property (hwLoad[0] [*4]);
  COV_PWDN_WRITE: cover property (pwdn_q[3] && opCode && cmd.mask[3]);
  COV_REFUSED: cover property (pslverr && cmdHit);
  COV_STROBE_MASKED: cover property (!hwSyncN && !hwEn_q[1]);

endmodule

// ===== inc/quad_dac_pkg.sv
package quad_dac_pkg;

  // ****************************************************************
  // Sizes and bus layout
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int CODE_W_DEF = 12;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACT0 = 8'h10;
  localparam logic [7:0] OFF_PEND0 = 8'h20;

  // ****************************************************************
  // Commands and modes
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_CODE = 4'h0,
    OP_LOAD = 4'h1,
    OP_CODE_LOAD = 4'h2,
    OP_HW_CFG = 4'h3,
    OP_REF = 4'h4,
    OP_SOFT_WIPE = 4'h5,
    OP_SOFT_RESTART = 4'h6,
    OP_POWER = 4'h7
  } cmd_op_e;

  typedef enum logic [1:0] {
    REF_EXT = 2'h0,
    REF_2V048 = 2'h1,
    REF_2V500 = 2'h2,
    REF_4V096 = 2'h3
  } ref_sel_e;

  // The command word: data in bits 27:16, mask in 7:4, opcode in 3:0.
  typedef struct packed {
    logic [3:0] rsvdHi;
    logic [11:0] data;
    logic [7:0] rsvdMid;
    logic [3:0] mask;
    cmd_op_e op;
  } cmd_s;

  typedef struct packed {
    logic [13:0] rsvdHi;
    logic wipe;
    logic cal;
    logic [5:0] rsvdMid;
    ref_sel_e refSel;
    logic [3:0] pwdn;
    logic [3:0] hwEn;
  } status_s;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [3:0] RST_HW_EN = 4'hF;
  localparam logic [3:0] RST_PWDN = 4'h0;
  localparam ref_sel_e RST_REF = REF_EXT;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int CAL_TIME_US = 200;
  localparam int CAL_CYCLES =
    (CAL_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ===== verilog/sync_two_ff.sv
`timescale 1ns/10ps
module sync_two_ff #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic arst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== verilog/calib_timer.sv
`timescale 1ns/10ps
module calib_timer #(
  parameter int CYCLES = 25000
) (
  input wire logic clk,
  input wire logic rst,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] START = CW'(CYCLES);

  logic [CW-1:0] count_q;
  logic busy_q;

  // The busy flag is a flop of its own so the output never glitches on
  // a count decode; it drops at the same edge at which the count ends.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= START;
      busy_q <= 1'b1;
    end else begin
      count_q <= (count_q != '0) ? count_q - CW'(1) : count_q;
      busy_q <= count_q > CW'(1);
    end
  end

  assign busy = busy_q;

endmodule

// ===== bench/apb_host_model.sv
`timescale 1ns/10ps
module apb_host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic hwUpdateN
);
  // ****************************************************************
  // Command host
  // ****************************************************************
  logic [31:0] rdData;
  logic errSeen;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hwUpdateN = 1'b1;
  end

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setStrobe(input logic v);
    hwUpdateN <= v;
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
  import quad_dac_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic clk, rst, asyncWipeN, psel, penable, pwrite, pready, pslverr;
  logic hwUpdateN, calibrating;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [47:0] activeCode;
  logic [3:0] powerDown;
  ref_sel_e refSel;
  int numErrors = 0;
  int totalChecks = 0;

  quad_dac_double_buffer_ctrl #(.CAL_CYCLES(8)) DUT (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hwUpdateN(hwUpdateN), .asyncWipeN(asyncWipeN),
    .activeCode(activeCode), .powerDown(powerDown), .refSel(refSel),
    .calibrating(calibrating));

  apb_host_model host (
    .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .hwUpdateN(hwUpdateN));

  task automatic completeRun();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [3:0] op, input logic [3:0] m,
                   input logic [11:0] d);
    host.xfer(1'b1, OFF_CMD, {4'h0, d, 8'h00, m, op});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0);
    chk(48'(host.rdData), 48'(e));
  endtask

  // Outputs are read one edge later, where they are settled.
  task automatic outIs(input logic [47:0] e);
    @(posedge clk);
    chk(activeCode, e);
  endtask

  task automatic tCal();
    w(OP_CODE_LOAD, 4'h1, 12'h0FF);
    chk(48'(host.errSeen), 48'h1);
    rd(OFF_STATUS, 32'h0001000F);
    for (int n = 0; n < 30 && calibrating !== 1'b0; n++) begin
      @(posedge clk);
    end
    chk(48'(calibrating), 48'h0);
    outIs(48'h0);
    rd(OFF_STATUS, 32'h0000000F);
    rd(8'h08, 32'h0);
    chk(48'(host.errSeen), 48'h1);
  endtask

  task automatic tBuffer();
    w(OP_CODE, 4'h5, 12'hABC);
    outIs(48'h0);
    rd(OFF_PEND0 + 8'h08, 32'hABC);
    w(OP_LOAD, 4'h5, 12'h0);
    outIs(48'h000ABC000ABC);
    w(OP_CODE_LOAD, 4'h2, 12'h123);
    outIs(48'h000ABC123ABC);
  endtask

  task automatic tPower();
    w(OP_POWER, 4'hF, 12'h0);
    rd(OFF_STATUS, 32'h000000FF);
    chk(48'(powerDown), 48'hF);
    outIs(48'h000ABC123ABC);
    w(OP_CODE, 4'h8, 12'h555);
    w(OP_LOAD, 4'h8, 12'h0);
    outIs(48'h555ABC123ABC);
    w(OP_POWER, 4'h0, 12'h0);
    @(posedge clk);
    chk(48'(powerDown), 48'h0);
  endtask

  task automatic tRef();
    for (int i = 1; i < 4; i++) begin
      w(OP_REF, 4'h0, 12'(i));
      @(posedge clk);
      chk(48'(refSel), 48'(i));
    end
    w(OP_SOFT_RESTART, 4'h0, 12'h0);
    outIs(48'h0);
    rd(OFF_STATUS, 32'h0000000F);
    rd(OFF_PEND0, 32'h0);
  endtask

  task automatic tStrobe();
    w(OP_CODE, 4'hF, 12'h777);
    w(OP_HW_CFG, 4'h1, 12'h0);
    host.setStrobe(1'b0);
    repeat (4) @(posedge clk);
    outIs(48'h000000000777);
    w(OP_CODE, 4'h1, 12'h321);
    outIs(48'h000000000321);
    host.setStrobe(1'b1);
    w(OP_HW_CFG, 4'hF, 12'h0);
    w(OP_LOAD, 4'hF, 12'h0);
    outIs(48'h777777777321);
    w(OP_SOFT_WIPE, 4'h0, 12'h0);
    outIs(48'h0);
    rd(OFF_PEND0 + 8'h04, 32'h0);
  endtask

  task automatic tClear();
    w(OP_CODE_LOAD, 4'hF, 12'h9A5);
    outIs(48'h9A59A59A59A5);
    asyncWipeN <= 1'b0;
    outIs(48'h0);
    rd(OFF_STATUS, 32'h0002000F);
    w(OP_CODE_LOAD, 4'hF, 12'h001);
    chk(48'(host.errSeen), 48'h1);
    asyncWipeN <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_PEND0, 32'h0);
    w(OP_CODE_LOAD, 4'h1, 12'h0A5);
    chk(48'(host.errSeen), 48'h0);
    outIs(48'h0000000000A5);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    asyncWipeN = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tCal();
    tBuffer();
    tPower();
    tRef();
    tStrobe();
    tClear();
    completeRun();
  end

  // A hang must not stall the run; the whole sequence needs about 1 us.
  initial begin
    #40000;
    numErrors++;
    completeRun();
  end
endmodule
